// ### logic/fqc_defs.svh
// Purpose: Offsets, field positions, reset values and sizes of the byte queue block
// Assumes: Byte wide register port, one clock
// Notes:   Definitions only
`ifndef FQC_DEFS_SVH
`define FQC_DEFS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define FQC_OFS_CONTROL    8'h02
`define FQC_OFS_WMARK_LOW  8'h03
`define FQC_OFS_LENGTH     8'h04
`define FQC_OFS_DATA       8'h05
`define FQC_OFS_STATUS_A   8'h06
`define FQC_OFS_ENABLE_A   8'h08
`define FQC_OFS_ERROR      8'h0A

// ********************************************************************
// Field positions
// ********************************************************************
`define FQC_CTL_CAP_SEL    7
`define FQC_CTL_NEAR_FULL  6
`define FQC_CTL_NEAR_EMPTY 5
`define FQC_CTL_FLUSH      4
`define FQC_CTL_WMARK_MSB  2
`define FQC_CTL_LEN_HI     1
`define FQC_CTL_LEN_LO     0
`define FQC_EVT_ERROR      1
`define FQC_EVT_NEAR_EMPTY 2
`define FQC_EVT_NEAR_FULL  3
`define FQC_ERR_OVERFLOW   4

// ********************************************************************
// Reset values and sizes
// ********************************************************************
`define FQC_RST_BYTE       8'h00
`define FQC_RST_WMARK      9'h000
`define FQC_RST_COUNT      10'h000
`define FQC_RST_PTR        9'h000
`define FQC_CAP_LARGE      10'h200
`define FQC_CAP_SMALL      10'h0FF
`define FQC_DEPTH          512
`define FQC_SKID_DEPTH     2'h2

`endif

// ### logic/fqc_pkg.sv
// Purpose: Types shared by the byte queue block
// Assumes: Constants come from fqc_defs.svh
// Notes:   Types only
package fqc_pkg;

	typedef logic [7:0] fqc_byte_t;
	typedef logic [9:0] fqc_count_t;
	typedef logic [8:0] fqc_ptr_t;

	typedef enum logic
	{
		FQC_CAP_512 = 1'b0,
		FQC_CAP_255 = 1'b1
	} fqc_cap_e;

endpackage : fqc_pkg

// ### logic/fqc_stream_if.sv
// Purpose: Byte stream with valid and ready between the block's own modules
// Assumes: Single clock
// Notes:   A word moves when valid and ready are both high
`timescale 1ns/1ps
interface fqc_stream_if;
	logic       valid;
	logic       ready;
	logic [7:0] data;

	modport src
	(
		output valid,
		output data,
		input  ready
	);

	modport snk
	(
		input  valid,
		input  data,
		output ready
	);
endinterface : fqc_stream_if

// ### logic/fqc_skid.sv
// Purpose: Two entry buffer in the engine write path
// Assumes: Single clock, active low asynchronous reset
// Notes:   Flush empties both entries
`timescale 1ns/1ps
module fqc_skid
	import fqc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   rst_n,
	input  wire logic   flush,
	fqc_stream_if.snk   up,
	fqc_stream_if.src   dn
);
`include "fqc_defs.svh"

	logic [7:0] entry [0:1];
	logic       head;
	logic [1:0] used;
	logic       push;
	logic       pop;

	assign push     = up.valid && up.ready;
	assign pop      = dn.valid && dn.ready;
	assign up.ready = (used != `FQC_SKID_DEPTH);
	assign dn.valid = (used != 2'h0);
	assign dn.data  = entry[head];

	// ********************************************************************
	// Occupancy and read position
	// ********************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			used <= 2'h0;
			head <= 1'b0;
		end
		else if (flush)
		begin
			used <= 2'h0;
			head <= 1'b0;
		end
		else
		begin
			used <= 2'(used + {1'b0, push} - {1'b0, pop});
			if (pop)
				head <= ~head;
		end
	end

	// ********************************************************************
	// Storage
	// ********************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			entry[0] <= `FQC_RST_BYTE;
			entry[1] <= `FQC_RST_BYTE;
		end
		else if (push)
			entry[head ^ used[0]] <= up.data;
	end

endmodule : fqc_skid

// ### logic/fqc_top.sv
// Contract
// - Writing one to the flush bit resets both queue pointers.
// - After flush the count reads zero, old bytes gone, full capacity free.
// - Capacity is 512 bytes, or 255 bytes when the size select bit is one.
// - Each stored byte adds one to the count, each removed byte subtracts one.
// - Count readable in length register; high bits sit in control register.
// - Watermark high bit in register 02h bit 2, low byte in register 03h.
// - A write into a full queue sets overflow and the error event flag.
// - One watermark serves both alerts: free space and stored bytes.
// - Near full is one when capacity minus count is at most watermark.
// - Near empty is one when count is at most the watermark.
// - Near empty rising with its enable set raises the interrupt pin.
// - Near full rising with its enable set raises the interrupt pin.
// - In 255 byte mode length and watermark use one byte, else two.
//
// Purpose: Shared byte queue with flush, size select, level count and watermark alerts
// Assumes: Host register port is synchronous to REF_CLK; engine streams use valid and ready
// Notes:   Host data register accesses take priority over engine transfers in the same cycle
`timescale 1ns/1ps
module fqc_top
	import fqc_pkg::*;
#(
	parameter int DEPTH = `FQC_DEPTH
)
(
	input  wire logic       REF_CLK,
	input  wire logic       NRST,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	input  wire logic [7:0] ENG_IN_DATA,
	input  wire logic       ENG_IN_VALID,
	output logic            ENG_IN_READY,
	output logic      [7:0] ENG_OUT_DATA,
	output logic            ENG_OUT_VALID,
	input  wire logic       ENG_OUT_READY,
	output logic            IRQ
);
`include "fqc_defs.svh"

	// ********************************************************************
	// Declarations
	// ********************************************************************
	fqc_byte_t  mem [0:DEPTH-1];
	fqc_ptr_t   wr_ptr;
	fqc_ptr_t   rd_ptr;
	fqc_count_t queue_stored_count;
	fqc_cap_e   queue_capacity_select;
	logic [8:0] fill_watermark;
	logic [8:0] wmark_eff;
	fqc_count_t capacity;
	logic       near_full_alert;
	logic       near_empty_alert;
	logic       near_full_q;
	logic       near_empty_q;
	logic       queue_overflow_flag;
	logic [7:0] event_status_reg_a;
	logic [7:0] event_enable_reg_a;
	logic [7:0] queue_control_reg;
	logic       queue_flush;
	logic       is_full;
	logic       is_empty;
	logic       host_wr_data;
	logic       host_rd_data;
	logic       host_push;
	logic       host_pop;
	logic       host_overflow;
	logic       eng_push;
	logic       eng_pop;
	logic       do_push;
	logic       do_pop;
	fqc_byte_t  push_data;
	logic       out_free;
	logic [7:0] next_rdata;
	logic [7:0] status_set;
	logic       pin_active;
	logic       next_in_ready;

	fqc_stream_if eng_in ();
	fqc_stream_if eng_q  ();

	// ********************************************************************
	// Engine write path through the two entry buffer
	// ********************************************************************
	// Only a word offered against the registered ready enters the buffer
	assign eng_in.valid = ENG_IN_VALID && ENG_IN_READY;
	// Ready falls on the same edge that fills the buffer, so an accepted word always has room
	assign next_in_ready = queue_flush || eng_push || (eng_in.ready && !(eng_q.valid && eng_in.valid));
	assign eng_in.data  = ENG_IN_DATA;

	fqc_skid u_skid
	(
		.clk   (REF_CLK),
		.rst_n (NRST),
		.flush (queue_flush),
		.up    (eng_in),
		.dn    (eng_q)
	);

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			ENG_IN_READY <= 1'b0;
		else
			ENG_IN_READY <= next_in_ready;
	end

	// ********************************************************************
	// Capacity, watermark and access decode
	// ********************************************************************
	assign capacity  = (queue_capacity_select == FQC_CAP_255) ? `FQC_CAP_SMALL : `FQC_CAP_LARGE;
	assign wmark_eff = (queue_capacity_select == FQC_CAP_255) ?
		{1'b0, fill_watermark[7:0]} : fill_watermark;
	assign is_full   = (queue_stored_count >= capacity);
	assign is_empty  = (queue_stored_count == `FQC_RST_COUNT);

	assign queue_flush  = REG_WR && (REG_ADDR == `FQC_OFS_CONTROL) && REG_WDATA[`FQC_CTL_FLUSH];
	assign host_wr_data = REG_WR && (REG_ADDR == `FQC_OFS_DATA);
	assign host_rd_data = REG_RD && (REG_ADDR == `FQC_OFS_DATA);

	// Host write into a full queue is dropped and flagged
	assign host_push     = host_wr_data && !is_full && !queue_flush;
	assign host_overflow = host_wr_data && is_full && !queue_flush;
	assign host_pop      = host_rd_data && !is_empty && !queue_flush;

	// Engine push stalls while full, so the buffer holds its words
	assign eng_push    = eng_q.valid && !is_full && !host_wr_data && !queue_flush;
	assign eng_q.ready = eng_push;
	assign out_free    = !ENG_OUT_VALID || ENG_OUT_READY;
	assign eng_pop     = out_free && !is_empty && !host_rd_data && !queue_flush;

	assign do_push   = host_push || eng_push;
	assign do_pop    = host_pop || eng_pop;
	assign push_data = host_wr_data ? REG_WDATA : eng_q.data;

	// ********************************************************************
	// Pointers and count
	// ********************************************************************
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			wr_ptr <= `FQC_RST_PTR;
			rd_ptr <= `FQC_RST_PTR;
		end
		else if (queue_flush)
		begin
			wr_ptr <= `FQC_RST_PTR;
			rd_ptr <= `FQC_RST_PTR;
		end
		else
		begin
			if (do_push)
				wr_ptr <= (10'(wr_ptr) + 10'h001 >= capacity) ? `FQC_RST_PTR : 9'(wr_ptr + 9'h001);
			if (do_pop)
				rd_ptr <= (10'(rd_ptr) + 10'h001 >= capacity) ? `FQC_RST_PTR : 9'(rd_ptr + 9'h001);
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			queue_stored_count <= `FQC_RST_COUNT;
		else if (queue_flush)
			queue_stored_count <= `FQC_RST_COUNT;
		else
			queue_stored_count <= 10'(queue_stored_count + {9'h000, do_push} - {9'h000, do_pop});
	end

	always_ff @(posedge REF_CLK)
	begin
		if (do_push)
			mem[wr_ptr] <= push_data;
	end

	// ********************************************************************
	// Engine read stage
	// ********************************************************************
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			ENG_OUT_VALID <= 1'b0;
			ENG_OUT_DATA  <= `FQC_RST_BYTE;
		end
		else if (queue_flush)
			ENG_OUT_VALID <= 1'b0;
		else if (eng_pop)
		begin
			ENG_OUT_VALID <= 1'b1;
			ENG_OUT_DATA  <= mem[rd_ptr];
		end
		else if (ENG_OUT_READY)
			ENG_OUT_VALID <= 1'b0;
	end

	// ********************************************************************
	// Alerts
	// ********************************************************************
	assign near_full_alert  = ((capacity - queue_stored_count) <= {1'b0, wmark_eff});
	assign near_empty_alert = (queue_stored_count <= {1'b0, wmark_eff});

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			near_full_q  <= 1'b0;
			near_empty_q <= 1'b1;
		end
		else
		begin
			near_full_q  <= near_full_alert;
			near_empty_q <= near_empty_alert;
		end
	end

	// ********************************************************************
	// Configuration registers
	// ********************************************************************
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			queue_capacity_select <= FQC_CAP_512;
			fill_watermark        <= `FQC_RST_WMARK;
			event_enable_reg_a    <= `FQC_RST_BYTE;
		end
		else if (REG_WR)
		begin
			if (REG_ADDR == `FQC_OFS_CONTROL)
			begin
				queue_capacity_select <= fqc_cap_e'(REG_WDATA[`FQC_CTL_CAP_SEL]);
				fill_watermark[8]     <= REG_WDATA[`FQC_CTL_WMARK_MSB];
			end
			else if (REG_ADDR == `FQC_OFS_WMARK_LOW)
				fill_watermark[7:0] <= REG_WDATA;
			else if (REG_ADDR == `FQC_OFS_ENABLE_A)
				event_enable_reg_a <= REG_WDATA;
		end
	end

	// ********************************************************************
	// Event flags, set wins over a write-one clear
	// ********************************************************************
	always_comb
	begin
		status_set                      = 8'h00;
		status_set[`FQC_EVT_ERROR]      = host_overflow;
		status_set[`FQC_EVT_NEAR_EMPTY] = near_empty_alert && !near_empty_q;
		status_set[`FQC_EVT_NEAR_FULL]  = near_full_alert && !near_full_q;
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			event_status_reg_a <= `FQC_RST_BYTE;
		else if (REG_WR && (REG_ADDR == `FQC_OFS_STATUS_A))
			event_status_reg_a <= (event_status_reg_a & ~REG_WDATA) | status_set;
		else
			event_status_reg_a <= event_status_reg_a | status_set;
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			queue_overflow_flag <= 1'b0;
		else if (host_overflow)
			queue_overflow_flag <= 1'b1;
		else if (queue_flush)
			queue_overflow_flag <= 1'b0;
	end

	assign pin_active = |(event_status_reg_a & event_enable_reg_a);

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			IRQ <= 1'b0;
		else
			IRQ <= pin_active;
	end

	// ********************************************************************
	// Read data
	// ********************************************************************
	always_comb
	begin
		queue_control_reg                      = 8'h00;
		queue_control_reg[`FQC_CTL_CAP_SEL]    = queue_capacity_select;
		queue_control_reg[`FQC_CTL_NEAR_FULL]  = near_full_alert;
		queue_control_reg[`FQC_CTL_NEAR_EMPTY] = near_empty_alert;
		queue_control_reg[`FQC_CTL_WMARK_MSB]  = fill_watermark[8];
		if (queue_capacity_select == FQC_CAP_512)
		begin
			queue_control_reg[`FQC_CTL_LEN_HI] = queue_stored_count[9];
			queue_control_reg[`FQC_CTL_LEN_LO] = queue_stored_count[8];
		end
	end

	always_comb
	begin
		next_rdata = 8'h00;
		if (REG_ADDR == `FQC_OFS_CONTROL)
			next_rdata = queue_control_reg;
		else if (REG_ADDR == `FQC_OFS_WMARK_LOW)
			next_rdata = fill_watermark[7:0];
		else if (REG_ADDR == `FQC_OFS_LENGTH)
			next_rdata = queue_stored_count[7:0];
		else if (REG_ADDR == `FQC_OFS_DATA)
			next_rdata = is_empty ? 8'h00 : mem[rd_ptr];
		else if (REG_ADDR == `FQC_OFS_STATUS_A)
			next_rdata = event_status_reg_a;
		else if (REG_ADDR == `FQC_OFS_ENABLE_A)
			next_rdata = event_enable_reg_a;
		else if (REG_ADDR == `FQC_OFS_ERROR)
			next_rdata = {3'h0, queue_overflow_flag, 4'h0};
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			REG_RDATA <= `FQC_RST_BYTE;
		else if (REG_RD)
			REG_RDATA <= next_rdata;
	end

endmodule : fqc_top

// ### dv/fqc_top_props.sv
// Purpose: Port level assertions for the byte queue block
// Assumes: One clock domain, active low asynchronous reset
// Notes:   Bound to every fqc_top instance
`timescale 1ns/1ps
module fqc_top_props
	import fqc_pkg::*;
#(
	parameter int DEPTH = 512
)
(
	input wire logic       REF_CLK,
	input wire logic       NRST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic       ENG_IN_VALID,
	input wire logic [7:0] ENG_OUT_DATA,
	input wire logic       ENG_OUT_VALID,
	input wire logic       ENG_OUT_READY,
	input wire logic       IRQ
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	wire logic flush_wr = REG_WR && REG_ADDR == 8'h02 && REG_WDATA[4];
	wire logic rd_ctl   = REG_RD && REG_ADDR == 8'h02;
	wire logic rd_len   = REG_RD && REG_ADDR == 8'h04;
	wire logic wr_ena   = REG_WR && REG_ADDR == 8'h08;
	wire logic rd_unmap = REG_RD && !(REG_ADDR inside {8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0A});

	sequence s_flushed;
		(flush_wr && !ENG_IN_VALID) ##1 (!REG_WR && !ENG_IN_VALID) ##1 !ENG_IN_VALID;
	endsequence

	AST_UNMAPPED: assert property (rd_unmap |=> REG_RDATA == 8'h00)
		else $error("unmapped read returned data");
	AST_RD_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without a read");
	AST_FLUSH_SELFCLR: assert property (rd_ctl |=> !REG_RDATA[4])
		else $error("flush bit reads back set");
	AST_SMALL_HI: assert property (rd_ctl |=> (!REG_RDATA[7] || REG_RDATA[1:0] == 2'b00))
		else $error("count high bits set in small mode");
	AST_FLUSH_ZERO: assert property (s_flushed ##0 rd_len |=> REG_RDATA == 8'h00)
		else $error("count not zero after flush");
	AST_FLUSH_LOW: assert property (s_flushed ##0 rd_ctl |=> REG_RDATA[5])
		else $error("near empty clear after flush");
	AST_OUT_HOLD: assert property (ENG_OUT_VALID && !ENG_OUT_READY && !flush_wr
		|=> ENG_OUT_VALID && $stable(ENG_OUT_DATA))
		else $error("engine output dropped while stalled");
	AST_IRQ_OFF: assert property ((wr_ena && REG_WDATA == 8'h00) ##1 !wr_ena |=> !IRQ)
		else $error("interrupt with all enables clear");

	cover property (flush_wr);
	cover property ($rose(IRQ));
	cover property (ENG_OUT_VALID && ENG_OUT_READY);
endmodule : fqc_top_props

bind fqc_top fqc_top_props #(.DEPTH(DEPTH)) u_fqc_top_props
(
	.REF_CLK       (REF_CLK),
	.NRST          (NRST),
	.REG_ADDR      (REG_ADDR),
	.REG_WDATA     (REG_WDATA),
	.REG_WR        (REG_WR),
	.REG_RD        (REG_RD),
	.REG_RDATA     (REG_RDATA),
	.ENG_IN_VALID  (ENG_IN_VALID),
	.ENG_OUT_DATA  (ENG_OUT_DATA),
	.ENG_OUT_VALID (ENG_OUT_VALID),
	.ENG_OUT_READY (ENG_OUT_READY),
	.IRQ           (IRQ)
);

// ### dv/fqc_eng_model.sv
// Purpose: Engine side partner that feeds and drains the queue
// Assumes: Same clock as the queue
// Notes:   Sends an incrementing byte sequence, logs every byte taken
`timescale 1ns/1ps
module fqc_eng_model
	import fqc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       src_en,
	input  wire logic       sink_en,
	input  wire logic       in_ready,
	output logic      [7:0] in_data,
	output logic            in_valid,
	input  wire logic [7:0] out_data,
	input  wire logic       out_valid,
	output logic            out_ready
);
	// ****************************************************************
	// Source and sink
	// ****************************************************************
	fqc_byte_t seq;
	fqc_byte_t rx_q[$];

	// Idle data is inverted so a stale byte never passes as new
	assign in_data = in_valid ? seq : ~seq;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_valid  <= 1'b0;
			seq       <= 8'h00;
			out_ready <= 1'b0;
		end
		else
		begin
			if (in_valid && in_ready)
				seq <= seq + 8'h01;
			if (!in_valid || in_ready)
				in_valid <= src_en;
			out_ready <= sink_en;
		end
	end

	always @(posedge clk)
		if (out_valid && out_ready)
			rx_q.push_back(out_data);
endmodule : fqc_eng_model

// ### dv/fqc_top_tb.sv
// Purpose: Self checking bench for the byte queue block
// Assumes: Register port strobes are one cycle pulses
// Notes:   One byte parks in the engine output stage while the queue holds data and the sink is off
`timescale 1ns/1ps
module fqc_top_tb
	import fqc_pkg::*;
;
	// ****************************************************************
	// Harness
	// ****************************************************************
	logic       REF_CLK = 1'b0;
	logic       NRST, REG_WR, REG_RD, src_en, sink_en;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, ENG_IN_DATA, ENG_OUT_DATA;
	logic       ENG_IN_VALID, ENG_IN_READY, ENG_OUT_VALID, ENG_OUT_READY, IRQ;
	int         err_total = 0;
	int         n_tests = 0;
	fqc_byte_t  s0;

	always #2 REF_CLK = ~REF_CLK;

	fqc_top #(.DEPTH(512)) u_fqc_top
	(
		.REF_CLK(REF_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.ENG_IN_DATA(ENG_IN_DATA), .ENG_IN_VALID(ENG_IN_VALID), .ENG_IN_READY(ENG_IN_READY),
		.ENG_OUT_DATA(ENG_OUT_DATA), .ENG_OUT_VALID(ENG_OUT_VALID), .ENG_OUT_READY(ENG_OUT_READY), .IRQ(IRQ)
	);

	fqc_eng_model u_fqc_eng_model
	(
		.clk(REF_CLK), .rst_n(NRST), .src_en(src_en), .sink_en(sink_en),
		.in_ready(ENG_IN_READY), .in_data(ENG_IN_DATA), .in_valid(ENG_IN_VALID),
		.out_data(ENG_OUT_DATA), .out_valid(ENG_OUT_VALID), .out_ready(ENG_OUT_READY)
	);

	task automatic check(input fqc_byte_t seen, input fqc_byte_t exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask : idle

	task automatic wr(input fqc_byte_t a, input fqc_byte_t d);
		@(posedge REF_CLK);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= 1'b1;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
	endtask : wr

	task automatic rd(input fqc_byte_t a, input fqc_byte_t exp);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_RD   <= 1'b1;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		#1 check(REG_RDATA, exp);
	endtask : rd

	task automatic fill(input int n);
		for (int i = 0; i < n; i++)
			wr(8'h05, 8'(i));
	endtask : fill

	task automatic wait_rx(input int n);
		for (int k = 0; k < 3000 && u_fqc_eng_model.rx_q.size() < n; k++)
			@(posedge REF_CLK);
		idle(4);
	endtask : wait_rx

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		rd(8'h02, 8'h20);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h06, 8'h00);
		rd(8'h0A, 8'h00);
		rd(8'h0F, 8'h00);
		wr(8'h02, 8'h10);
		rd(8'h02, 8'h20);
	endtask : t_reset

	task automatic t_small;
		wr(8'h02, 8'h90);
		wr(8'h03, 8'h10);
		fill(256);
		rd(8'h04, 8'hFF);
		rd(8'h02, 8'hC0);
		wr(8'h05, 8'hEE);
		rd(8'h04, 8'hFF);
		rd(8'h0A, 8'h10);
		rd(8'h06, 8'h0A);
		sink_en <= 1'b1;
		wait_rx(256);
		for (int i = 0; i < 256; i++)
			check(u_fqc_eng_model.rx_q[i], 8'(i));
		check(8'(u_fqc_eng_model.rx_q.size() == 256), 8'h01);
		rd(8'h04, 8'h00);
		rd(8'h06, 8'h0E);
		sink_en <= 1'b0;
		u_fqc_eng_model.rx_q.delete();
	endtask : t_small

	task automatic t_flush;
		wr(8'h02, 8'h10);
		fill(5);
		rd(8'h04, 8'h04);
		wr(8'h02, 8'h10);
		rd(8'h04, 8'h00);
		rd(8'h0A, 8'h00);
		wr(8'h05, 8'hA1);
		wr(8'h05, 8'hA2);
		sink_en <= 1'b1;
		wait_rx(2);
		check(u_fqc_eng_model.rx_q[0], 8'hA1);
		check(u_fqc_eng_model.rx_q[1], 8'hA2);
		sink_en <= 1'b0;
		u_fqc_eng_model.rx_q.delete();
	endtask : t_flush

	task automatic t_wmark;
		wr(8'h03, 8'h00);
		wr(8'h02, 8'h14);
		fill(257);
		rd(8'h04, 8'h00);
		rd(8'h02, 8'h65);
		rd(8'h05, 8'h01);
		rd(8'h02, 8'h24);
		rd(8'h04, 8'hFF);
		fill(2);
		rd(8'h02, 8'h45);
		rd(8'h04, 8'h01);
	endtask : t_wmark

	task automatic t_irq;
		wr(8'h08, 8'h00);
		wr(8'h06, 8'hFF);
		idle(2);
		#1 check(IRQ, 8'h00);
		wr(8'h08, 8'h04);
		wr(8'h02, 8'h14);
		idle(3);
		#1 check(IRQ, 8'h01);
		rd(8'h06, 8'h04);
		wr(8'h06, 8'h04);
		idle(2);
		#1 check(IRQ, 8'h00);
		wr(8'h08, 8'h08);
		wr(8'h03, 8'hFE);
		wr(8'h05, 8'h55);
		wr(8'h05, 8'h56);
		idle(3);
		#1 check(IRQ, 8'h00);
		wr(8'h05, 8'h57);
		idle(3);
		#1 check(IRQ, 8'h01);
		rd(8'h06, 8'h08);
		wr(8'h08, 8'h00);
	endtask : t_irq

	// Host keeps off the data register while the engine streams
	task automatic t_engine;
		wr(8'h02, 8'h90);
		u_fqc_eng_model.rx_q.delete();
		s0 = u_fqc_eng_model.seq;
		src_en <= 1'b1;
		for (int k = 0; k < 2000 && ENG_IN_READY; k++)
			@(posedge REF_CLK);
		idle(8);
		#1 check(ENG_IN_READY, 8'h00);
		rd(8'h04, 8'hFF);
		rd(8'h0A, 8'h00);
		src_en  <= 1'b0;
		sink_en <= 1'b1;
		wait_rx(258);
		idle(8);
		for (int i = 0; i < u_fqc_eng_model.rx_q.size(); i++)
			check(u_fqc_eng_model.rx_q[i], 8'(s0 + i));
		check(u_fqc_eng_model.seq, 8'(s0 + u_fqc_eng_model.rx_q.size()));
		rd(8'h04, 8'h00);
	endtask : t_engine

	task automatic conclude;
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	initial
	begin
		{NRST, REG_WR, REG_RD, src_en, sink_en} = 5'h00;
		{REG_ADDR, REG_WDATA} = 16'h0000;
		idle(2);
		NRST <= 1'b1;
		t_reset();
		t_small();
		t_flush();
		t_wmark();
		t_irq();
		t_engine();
		conclude();
	end

	initial
	begin
		#100000;
		err_total++;
		conclude();
	end
endmodule : fqc_top_tb
